// ---- common/bcv_consts.svh ----
// Constants for the bridge connection verify block
`ifndef BCV_CONSTS_SVH
`define BCV_CONSTS_SVH

// Synchronised comparator indices
`define BCV_C_BRIDGE 0
`define BCV_C_PHA 1
`define BCV_C_PHB 2
`define BCV_C_AMPA 3
`define BCV_C_AMPB 4
`define BCV_C_LSA 5
`define BCV_C_LSB 6
`define BCV_NCMP 7

// Sticky flag indices, also the bit order of the read-clear vector
`define BCV_F_BRIDGE 0
`define BCV_F_AMPA 1
`define BCV_F_AMPB 2
`define BCV_F_LSA 3
`define BCV_F_LSB 4
`define BCV_F_VHA 5
`define BCV_F_VHB 6
`define BCV_F_VLA 7
`define BCV_F_VLB 8
`define BCV_F_PHCONN 9
`define BCV_NFLAG 10
`define BCV_FLAGS_RST 10'h000
`define BCV_FLAG_BIT_RST 1'b0

// Gate drive indices
`define BCV_G_HA 0
`define BCV_G_LA 1
`define BCV_G_HB 2
`define BCV_G_LB 3
`define BCV_NGATE 4
`define BCV_GATES_OFF 4'h0

// Threshold arithmetic
`define BCV_VTH_ONE 4'h1
`define BCV_VTH_STEP_V 4'h2
`define BCV_VTH_RST 4'h2
`define BCV_PERMILLE 16'h03e8
`define BCV_PERMILLE_RST 10'h000
`define BCV_SYNC_RST 1'b0

`endif

// ---- common/bcv_pkg.sv ----
// Types shared by the bridge connection verify block
package bcv_pkg;
`include "bcv_consts.svh"
   typedef logic [`BCV_NCMP-1:0] bcv_cmp_t;
   typedef logic [`BCV_NFLAG-1:0] bcv_flags_t;
   typedef logic [`BCV_NGATE-1:0] bcv_gate_t;
endpackage

// ---- common/bcv_cmp_if.sv ----
// Carrier for raw and synchronised comparator results
`timescale 1ns/10ps
interface bcv_cmp_if;
   bcv_pkg::bcv_cmp_t raw;
   bcv_pkg::bcv_cmp_t sync;
   modport sync_side (input raw, output sync);
   modport user (output raw, input sync);
endinterface

// ---- design/bcv_sync.sv ----
// Two-stage synchroniser bank for the comparator outputs
`timescale 1ns/10ps
`include "bcv_consts.svh"
module bcv_sync
(
   input wire logic core_clk, // Logic clock
   input wire logic rst_n,    // Power-on reset, active low
   bcv_cmp_if.sync_side cmp   // Raw in, synchronised out
);
   bcv_pkg::bcv_cmp_t stage1_reg;
   bcv_pkg::bcv_cmp_t stage2_reg;

   // One pair of flops per comparator; stage 1 feeds only stage 2
   genvar i;
   generate
      for (i = 0; i < `BCV_NCMP; i++)
      begin : g_bit
         always_ff @(posedge core_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               stage1_reg[i] <= `BCV_SYNC_RST;
               stage2_reg[i] <= `BCV_SYNC_RST;
            end
            else
            begin
               stage1_reg[i] <= cmp.raw[i];
               stage2_reg[i] <= stage1_reg[i];
            end
         end
      end
   endgenerate

   assign cmp.sync = stage2_reg;
endmodule

// ---- design/bcv_top.sv ----
// Bridge terminal connection verification, fault flag and gate stop
// What this block does
// R1: Bridge, sense amp and source checks run always; sense amp checks set result bits only.
// R2: Bridge disconnect threshold is (select code plus one) times two volts.
// R3: Bridge disconnect sets its result bit, both high-side VDS bits, fault flag.
// R4: Bridge disconnect with stop-on-fault forces gates off until the condition ends.
// R5: Bridge result and its high-side VDS bits stay set until cleared.
// R6: Controller keeps threshold within four volts of supply below twelve volts.
// R7: Phase comparator drives its level pin and its phase state bit.
// R8: Six-bit phase code sets threshold at code/64 of bridge voltage.
// R9: An open sense amplifier input sets that amplifier's own result bit.
// R10: Source terminal open sets its result bit, low-side VDS bit, fault flag.
// R11: Source open with stop-on-fault forces gates off until it ends.
// R12: Source result bits and low-side VDS bits stay set until cleared.
// R13: Off-line test currents are active only while their command is set.
// R14: Off-line connection test sets only its result bit, nothing else.
// R15: Controller runs high-side and low-side tests on each phase.
// R16: Set bits clear only on power-on reset or when read.
// R17: A masked check makes no fault state, flag or result bit.
// R18: Phase-connected sets when pull-down command falls with comparator high.
// R19: Comparator outputs are synchronised before setting bits or the flag.
`timescale 1ns/10ps
`include "bcv_consts.svh"
module bcv_top
(
   input wire logic core_clk,                          // Logic clock, 25 MHz
   input wire logic rst_n,                             // Power-on reset, active low
   input wire logic bridge_open_cmp,                   // Supply minus bridge sense above threshold
   input wire logic phase_a_node_cmp,                  // Phase A above phase threshold
   input wire logic phase_b_node_cmp,                  // Phase B above phase threshold
   input wire logic amp_a_open_cmp,                    // Sense amp A input open
   input wire logic amp_b_open_cmp,                    // Sense amp B input open
   input wire logic low_source_return_a_cmp,           // Source A above open threshold
   input wire logic low_source_return_b_cmp,           // Source B above open threshold
   input wire logic [1:0] bridge_open_threshold_sel,   // Bridge disconnect threshold code
   input wire logic [5:0] phase_threshold_code,        // Phase threshold code
   input wire logic stop_on_fault,                     // Stop all gates on fault
   input wire logic mask_bridge_check,                 // Disable bridge disconnect check
   input wire logic mask_source_check,                 // Disable source open checks
   input wire logic mask_amp_check,                    // Disable sense amp open checks
   input wire logic phase_pulldown_test,               // High-side test command
   input wire logic phase_pullup_test,                 // Low-side test command
   input wire logic phase_test_sel,                    // Phase under test, 1 is B
   input wire logic [3:0] gate_cmd,                    // Requested gate drives
   input wire logic [9:0] flag_read_clr,               // Per-bit clear on serial read
   output logic [3:0] bridge_open_threshold_volts,     // Selected threshold in volts
   output logic [9:0] phase_threshold_permille,        // Phase threshold, tenths of percent
   output logic phase_a_level_out,                     // Phase A level pin
   output logic phase_b_level_out,                     // Phase B level pin
   output logic phase_a_state_bit,                     // Phase A state result bit
   output logic phase_b_state_bit,                     // Phase B state result bit
   output logic pulldown_current_en,                   // Pull-down test current on
   output logic pullup_current_en,                     // Pull-up test current on
   output logic [3:0] gate_drive,                      // Gate drives after fault gating
   output logic general_fault_flag,                    // General fault flag
   output logic bridge_open_flag,                      // Bridge disconnect result
   output logic amp_a_open_flag,                       // Sense amp A open result
   output logic amp_b_open_flag,                       // Sense amp B open result
   output logic low_source_a_open_flag,                // Source A open result
   output logic low_source_b_open_flag,                // Source B open result
   output logic vds_fault_high_a,                      // High-side A VDS fault
   output logic vds_fault_high_b,                      // High-side B VDS fault
   output logic vds_fault_low_a,                       // Low-side A VDS fault
   output logic vds_fault_low_b,                       // Low-side B VDS fault
   output logic phase_connected_flag                   // Phase connection verified
);
   bcv_cmp_if cmp_bus ();
   bcv_pkg::bcv_flags_t flags_reg;
   bcv_pkg::bcv_flags_t set_vec;
   bcv_pkg::bcv_gate_t gate_drive_reg;
   bcv_pkg::bcv_gate_t gate_drive_next;
   logic [3:0] vth_reg;
   logic [3:0] vth_next;
   logic [9:0] permille_reg;
   logic [15:0] permille_prod;
   logic fault_reg;
   logic level_a_reg;
   logic level_b_reg;
   logic pd_en_reg;
   logic pu_en_reg;
   logic pd_prev_reg;
   logic pu_prev_reg;
   logic bridge_hit;
   logic lsa_hit;
   logic lsb_hit;
   logic ampa_hit;
   logic ampb_hit;
   logic fault_active;
   logic sel_cmp;
   logic pd_fall;
   logic pu_fall;
   logic phconn_hit;

   // Raw comparator bundle into the synchroniser
   assign cmp_bus.raw = {low_source_return_b_cmp, low_source_return_a_cmp, amp_b_open_cmp,
                         amp_a_open_cmp, phase_b_node_cmp, phase_a_node_cmp, bridge_open_cmp};

   // Synchronise every comparator before use
   bcv_sync u_sync
   (
      .core_clk (core_clk),
      .rst_n (rst_n),
      .cmp (cmp_bus.sync_side)
   ); // see R19

   // Live check results, each gated by its mask
   assign bridge_hit = cmp_bus.sync[`BCV_C_BRIDGE] & ~mask_bridge_check; // see R17
   assign lsa_hit = cmp_bus.sync[`BCV_C_LSA] & ~mask_source_check;       // see R17
   assign lsb_hit = cmp_bus.sync[`BCV_C_LSB] & ~mask_source_check;
   assign ampa_hit = cmp_bus.sync[`BCV_C_AMPA] & ~mask_amp_check;
   assign ampb_hit = cmp_bus.sync[`BCV_C_AMPB] & ~mask_amp_check;
   assign fault_active = bridge_hit | lsa_hit | lsb_hit;                  // see R3, R10

   // Off-line phase test: result taken on the falling command edge
   assign sel_cmp = phase_test_sel ? cmp_bus.sync[`BCV_C_PHB] : cmp_bus.sync[`BCV_C_PHA];
   assign pd_fall = pd_prev_reg & ~phase_pulldown_test;
   assign pu_fall = pu_prev_reg & ~phase_pullup_test;
   assign phconn_hit = (pd_fall & sel_cmp) | (pu_fall & ~sel_cmp);        // see R18, R14

   // Set sources for the sticky flags
   assign set_vec[`BCV_F_BRIDGE] = bridge_hit;                            // see R1, R3
   assign set_vec[`BCV_F_VHA] = bridge_hit;                               // see R3
   assign set_vec[`BCV_F_VHB] = bridge_hit;                               // see R3
   assign set_vec[`BCV_F_AMPA] = ampa_hit;                                // see R9
   assign set_vec[`BCV_F_AMPB] = ampb_hit;                                // see R9
   assign set_vec[`BCV_F_LSA] = lsa_hit;                                  // see R10
   assign set_vec[`BCV_F_LSB] = lsb_hit;                                  // see R10
   assign set_vec[`BCV_F_VLA] = lsa_hit;                                  // see R10
   assign set_vec[`BCV_F_VLB] = lsb_hit;                                  // see R10
   assign set_vec[`BCV_F_PHCONN] = phconn_hit;                            // see R14

   // Gate stop while a connection fault is live
   assign gate_drive_next = (stop_on_fault & fault_active) ? `BCV_GATES_OFF : gate_cmd; // see R4, R11

   // Threshold decode
   assign vth_next = ({2'h0, bridge_open_threshold_sel} + `BCV_VTH_ONE) * `BCV_VTH_STEP_V; // see R2
   assign permille_prod = {10'h000, phase_threshold_code} * `BCV_PERMILLE;                 // see R8

   // Sticky flags: set wins over read clear, reset only by power-on
   genvar i;
   generate
      for (i = 0; i < `BCV_NFLAG; i++)
      begin : g_flag
         always_ff @(posedge core_clk or negedge rst_n)
         begin
            if (!rst_n)
               flags_reg[i] <= `BCV_FLAG_BIT_RST;
            else
               flags_reg[i] <= set_vec[i] | (flags_reg[i] & ~flag_read_clr[i]); // see R5, R12, R16
         end
      end
   endgenerate

   // Fault flag and gate drive
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fault_reg <= 1'b0;
         gate_drive_reg <= `BCV_GATES_OFF;
      end
      else
      begin
         fault_reg <= fault_active;      // see R4, R11
         gate_drive_reg <= gate_drive_next;
      end
   end

   // Phase level pins and state bits
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         level_a_reg <= 1'b0;
         level_b_reg <= 1'b0;
      end
      else
      begin
         level_a_reg <= cmp_bus.sync[`BCV_C_PHA]; // see R7
         level_b_reg <= cmp_bus.sync[`BCV_C_PHB]; // see R7
      end
   end

   // Off-line test currents follow their commands only
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pd_en_reg <= 1'b0;
         pu_en_reg <= 1'b0;
         pd_prev_reg <= 1'b0;
         pu_prev_reg <= 1'b0;
      end
      else
      begin
         pd_en_reg <= phase_pulldown_test; // see R13
         pu_en_reg <= phase_pullup_test;   // see R13
         pd_prev_reg <= phase_pulldown_test;
         pu_prev_reg <= phase_pullup_test;
      end
   end

   // Threshold outputs
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         vth_reg <= `BCV_VTH_RST;
         permille_reg <= `BCV_PERMILLE_RST;
      end
      else
      begin
         vth_reg <= vth_next;
         permille_reg <= permille_prod[15:6];
      end
   end

   // Output wiring from flops
   assign bridge_open_threshold_volts = vth_reg;
   assign phase_threshold_permille = permille_reg;
   assign phase_a_level_out = level_a_reg;
   assign phase_b_level_out = level_b_reg;
   assign phase_a_state_bit = level_a_reg;
   assign phase_b_state_bit = level_b_reg;
   assign pulldown_current_en = pd_en_reg;
   assign pullup_current_en = pu_en_reg;
   assign gate_drive = gate_drive_reg;
   assign general_fault_flag = fault_reg;
   assign bridge_open_flag = flags_reg[`BCV_F_BRIDGE];
   assign amp_a_open_flag = flags_reg[`BCV_F_AMPA];
   assign amp_b_open_flag = flags_reg[`BCV_F_AMPB];
   assign low_source_a_open_flag = flags_reg[`BCV_F_LSA];
   assign low_source_b_open_flag = flags_reg[`BCV_F_LSB];
   assign vds_fault_high_a = flags_reg[`BCV_F_VHA];
   assign vds_fault_high_b = flags_reg[`BCV_F_VHB];
   assign vds_fault_low_a = flags_reg[`BCV_F_VLA];
   assign vds_fault_low_b = flags_reg[`BCV_F_VLB];
   assign phase_connected_flag = flags_reg[`BCV_F_PHCONN];

   // Checks on the block's own behaviour
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_bridge_sets_all: assert property (bridge_hit |=> bridge_open_flag && vds_fault_high_a && vds_fault_high_b
                                       && general_fault_flag) // see R3
      else $error("bridge disconnect did not set its bits and flag");

   a_bridge_sticky: assert property (bridge_open_flag && !flag_read_clr[`BCV_F_BRIDGE] |=> bridge_open_flag) // see R5
      else $error("bridge result bit dropped without a read");

   a_source_sets: assert property (lsa_hit |=> low_source_a_open_flag && vds_fault_low_a && general_fault_flag) // see R10
      else $error("source open A did not set its bits and flag");

   a_source_sticky: assert property (vds_fault_low_b && !flag_read_clr[`BCV_F_VLB] |=> vds_fault_low_b) // see R12
      else $error("low-side VDS bit dropped without a read");

   a_gates_stopped: assert property (stop_on_fault && fault_active |=> gate_drive == `BCV_GATES_OFF) // see R4
      else $error("gates not forced off during fault");

   a_gates_resume: assert property (!fault_active |=> gate_drive == $past(gate_cmd)) // see R11
      else $error("gates did not follow command without fault");

   a_flag_clears: assert property (fault_reg && !fault_active |=> !general_fault_flag) // see R4
      else $error("fault flag did not clear after condition ended");

   a_mask_quiet: assert property ($rose(bridge_open_flag) |-> $past(!mask_bridge_check)) // see R17
      else $error("masked bridge check set its bit");

   a_sync_latency: assert property ($rose(amp_a_open_flag) |-> $past(amp_a_open_cmp, 3)) // see R19
      else $error("amp open bit set without synchronised cause");

   a_amp_set: assert property (ampb_hit |=> amp_b_open_flag) // see R9
      else $error("amp B open bit not set");

   a_read_clear: assert property (amp_a_open_flag && flag_read_clr[`BCV_F_AMPA] && !ampa_hit |=> !amp_a_open_flag) // see R16
      else $error("read did not clear amp A open bit");

   a_phconn_cause: assert property ($rose(phase_connected_flag) |-> $past(pd_fall || pu_fall)) // see R18
      else $error("phase connected set without command release");

   a_phconn_set: assert property (pd_fall && sel_cmp |=> phase_connected_flag) // see R18
      else $error("phase connected not set on pull-down release");

   a_level_state: assert property (phase_a_level_out == phase_a_state_bit
                                   && (phase_b_level_out == $past(cmp_bus.sync[`BCV_C_PHB]))) // see R7
      else $error("phase level pin and state bit disagree");

   // Skips the first edge after reset, where the flop still shows its reset value
   a_threshold_code: assert property ($past(rst_n) |-> bridge_open_threshold_volts
                                      == ({2'h0, $past(bridge_open_threshold_sel)} + `BCV_VTH_ONE) * `BCV_VTH_STEP_V) // see R2
      else $error("bridge threshold mismatch");

   a_test_current: assert property (pulldown_current_en |-> $past(phase_pulldown_test)) // see R13
      else $error("pull-down current on without command");

   c_bridge_stop: cover property (stop_on_fault && bridge_hit ##1 gate_drive == `BCV_GATES_OFF);
   c_source_open: cover property (lsb_hit ##1 low_source_b_open_flag);
   c_phconn_low_side: cover property (pu_fall && !sel_cmp ##1 phase_connected_flag);
   c_read_clear: cover property (bridge_open_flag && flag_read_clr[`BCV_F_BRIDGE] && !bridge_hit ##1 !bridge_open_flag);
endmodule

// ---- tb/bcv_ctrl_model.sv ----
// Controller model: gate requests, threshold choice, phase tests, reads
`timescale 1ns/10ps
module bcv_ctrl_model
(
   input wire logic core_clk,                 // Logic clock
   output logic [3:0] gate_cmd,               // Gate requests
   output logic [1:0] bridge_open_threshold_sel, // Threshold code
   output logic phase_pulldown_test,          // High-side test command
   output logic phase_pullup_test,            // Low-side test command
   output logic phase_test_sel,               // Phase under test
   output logic [9:0] flag_read_clr           // Read-clear pulses
);
   // Idle controller from time zero
   initial
   begin
      gate_cmd = 4'h0;
      bridge_open_threshold_sel = 2'h0;
      phase_pulldown_test = 1'b0;
      phase_pullup_test = 1'b0;
      phase_test_sel = 1'b0;
      flag_read_clr = 10'h000;
   end
   // Gate and threshold settings, changed after a falling edge
   task automatic set_cfg(input logic [3:0] g, input logic [1:0] s);
      @(negedge core_clk);
      gate_cmd = g;
      bridge_open_threshold_sel = s;
   endtask
   // Read flags, one-cycle clear pulse
   task automatic read_flags(input logic [9:0] m);
      @(negedge core_clk);
      flag_read_clr = m;
      @(negedge core_clk);
      flag_read_clr = 10'h000;
   endtask
   // Gate on for the side under test and test current on, at the same falling edge
   task automatic start_test(input logic up, input logic ph);
      @(negedge core_clk);
      phase_test_sel = ph;
      gate_cmd = up ? (ph ? 4'h8 : 4'h2) : (ph ? 4'h4 : 4'h1);
      phase_pulldown_test = !up;
      phase_pullup_test = up;
   endtask
   // End of test: command falls, gates off
   task automatic end_test();
      @(negedge core_clk);
      phase_pulldown_test = 1'b0;
      phase_pullup_test = 1'b0;
      gate_cmd = 4'h0;
   endtask
endmodule

// ---- tb/bridge_connection_verify_bench.sv ----
// Self-checking bench for the bridge connection verify block
`timescale 1ns/10ps
module bridge_connection_verify_bench;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [6:0] cmp;
   logic [2:0] msk;
   logic bridge_open_cmp, phase_a_node_cmp, phase_b_node_cmp, amp_a_open_cmp, amp_b_open_cmp;
   logic low_source_return_a_cmp, low_source_return_b_cmp, stop_on_fault;
   logic mask_bridge_check, mask_source_check, mask_amp_check;
   logic [5:0] phase_threshold_code;
   logic [1:0] bridge_open_threshold_sel;
   logic phase_pulldown_test, phase_pullup_test, phase_test_sel;
   logic [3:0] gate_cmd, gate_drive, bridge_open_threshold_volts;
   logic [9:0] flag_read_clr, phase_threshold_permille, flags, sticky, ex, rd;
   logic phase_a_level_out, phase_b_level_out, phase_a_state_bit, phase_b_state_bit;
   logic pulldown_current_en, pullup_current_en, general_fault_flag, bridge_open_flag;
   logic amp_a_open_flag, amp_b_open_flag, low_source_a_open_flag, low_source_b_open_flag;
   logic vds_fault_high_a, vds_fault_high_b, vds_fault_low_a, vds_fault_low_b, phase_connected_flag;
   logic live;
   int errors = 0;
   int checks = 0;
   int seed;

   // Comparator and mask vectors onto the ports
   assign {low_source_return_b_cmp, low_source_return_a_cmp, amp_b_open_cmp, amp_a_open_cmp} = cmp[6:3];
   assign {phase_b_node_cmp, phase_a_node_cmp, bridge_open_cmp} = cmp[2:0];
   assign {mask_amp_check, mask_source_check, mask_bridge_check} = msk;
   assign flags = {phase_connected_flag, vds_fault_low_b, vds_fault_low_a, vds_fault_high_b,
      vds_fault_high_a, low_source_b_open_flag, low_source_a_open_flag, amp_b_open_flag,
      amp_a_open_flag, bridge_open_flag};

   bcv_top bcv_top_inst (.*);
   bcv_ctrl_model bcv_ctrl_model_inst (.*);

   // Clock, 40 ns period
   always #20 core_clk = ~core_clk;

   // Sticky bits that a held comparator vector must set
   function automatic logic [9:0] exp_set(input logic [6:0] c, input logic [2:0] m);
      logic br, la, lb, aa, ab;
      br = c[0] & !m[0];
      la = c[5] & !m[1];
      lb = c[6] & !m[1];
      aa = c[3] & !m[2];
      ab = c[4] & !m[2];
      return {1'b0, lb, la, br, br, lb, la, ab, aa, br};
   endfunction

   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Verdict and end of run
   task automatic finish_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Watchdog against a hang
   initial
   begin
      #2000000;
      errors++;
      finish_test();
   end

   // Main sequence
   initial
   begin
      seed = $urandom(65);
      cmp = 7'h00;
      msk = 3'h0;
      stop_on_fault = 1'b0;
      phase_threshold_code = 6'h00;
      sticky = 10'h000;
      repeat (20) @(negedge core_clk);
      check(bridge_open_threshold_volts, 4'h2, "threshold in reset");
      check(flags, 10'h000, "flags in reset");
      rst_n = 1'b1;
      // Random live checks, masks changed only while comparators are quiet
      for (int i = 0; i < 48; i++)
      begin
         bcv_ctrl_model_inst.set_cfg(4'($urandom), i < 4 ? i[1:0] : 2'($urandom));
         cmp = 7'($urandom);
         stop_on_fault = (i < 4) ? 1'b1 : 1'($urandom);
         phase_threshold_code = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($urandom);
         repeat (3) @(negedge core_clk);
         ex = exp_set(cmp, msk);
         live = ex[0] | ex[3] | ex[4];
         sticky = sticky | ex;
         check(general_fault_flag, live, "fault flag");
         check(gate_drive, (stop_on_fault & live) ? 4'h0 : gate_cmd, "gate stop");
         check(flags, sticky, "result bits");
         check({phase_b_level_out, phase_a_level_out, phase_b_state_bit, phase_a_state_bit},
            {cmp[2], cmp[1], cmp[2], cmp[1]}, "phase level");
         check(bridge_open_threshold_volts, ({2'h0, bridge_open_threshold_sel} + 4'h1) * 4'h2, "bridge threshold");
         check(phase_threshold_permille, ({10'h000, phase_threshold_code} * 16'h03e8) / 16'h0040, "phase threshold");
         if (i % 4 == 3)
         begin
            cmp = 7'h00;
            repeat (3) @(negedge core_clk);
            check(general_fault_flag, 1'b0, "flag release");
            check(gate_drive, gate_cmd, "gates resume");
            check(flags, sticky, "bits held");
            rd = 10'($urandom);
            bcv_ctrl_model_inst.read_flags(rd);
            @(negedge core_clk);
            sticky = sticky & ~rd;
            check(flags, sticky, "read clear");
            msk = 3'($urandom & $urandom);
         end
      end
      bcv_ctrl_model_inst.read_flags(10'h3ff);
      $display("test live checks done");
      // Phase tests: both sides, both phases, pass and fail levels
      msk = 3'h0;
      for (int k = 0; k < 8; k++)
      begin
         cmp[2:1] = {k[2], k[2]};
         bcv_ctrl_model_inst.start_test(k[0], k[1]);
         repeat (3) @(negedge core_clk);
         check({pullup_current_en, pulldown_current_en, phase_connected_flag},
            k[0] ? 3'h4 : 3'h2, "test running");
         bcv_ctrl_model_inst.end_test();
         repeat (2) @(negedge core_clk);
         check({pullup_current_en, pulldown_current_en}, 2'h0, "current off");
         check(flags, {k[2] ^ k[0], 9'h000}, "phase connected");
         check(general_fault_flag, 1'b0, "no fault from test");
         bcv_ctrl_model_inst.read_flags(10'h200);
      end
      $display("test phase connection done");
      // Power-on reset in mid-run clears the sticky bits
      cmp = 7'h01;
      repeat (3) @(negedge core_clk);
      check(flags, exp_set(7'h01, 3'h0), "bridge bits before reset");
      rst_n = 1'b0;
      cmp = 7'h00;
      repeat (2) @(negedge core_clk);
      check(flags, 10'h000, "bits during power-on reset");
      rst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      check(flags, 10'h000, "bits after release");
      check(general_fault_flag, 1'b0, "flag after release");
      $display("test power-on reset done");
      finish_test();
   end
endmodule
